/* File: core/ucem_pkg.sv */
// Constants shared by the endpoint-zero control manager.
package ucem_pkg;

  // Register bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets.
  localparam logic [7:0] USB_STAT_ADDR  = 8'h00;
  localparam logic [7:0] INT_STAT_ADDR  = 8'h04;
  localparam logic [7:0] INT_MASK_ADDR  = 8'h08;
  localparam logic [7:0] OUT_CFG_ADDR   = 8'h0C;
  localparam logic [7:0] OUT_CNT_ADDR   = 8'h10;
  localparam logic [7:0] IN_CFG_ADDR    = 8'h14;
  localparam logic [7:0] IN_CNT_ADDR    = 8'h18;
  localparam logic [3:0] SETUP_BUF_PAGE = 4'h2;
  localparam logic [3:0] OUT_BUF_PAGE   = 4'h3;
  localparam logic [3:0] IN_BUF_PAGE    = 4'h4;

  // Endpoint configuration byte fields.
  localparam int CFG_W     = 5;
  localparam int CFG_EN    = 0;
  localparam int CFG_TOG   = 1;
  localparam int CFG_HOLD  = 2;
  localparam int CFG_STALL = 3;
  localparam int CFG_IE    = 4;
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;

  // Interrupt status and mask fields.
  localparam int INT_W     = 3;
  localparam int INT_SETUP = 0;
  localparam int INT_OUT   = 1;
  localparam int INT_IN    = 2;
  localparam logic [INT_W-1:0] INT_RESET = 3'h0;

  // Token codes from the serial engine.
  localparam logic [1:0] TOK_OUT   = 2'h0;
  localparam logic [1:0] TOK_IN    = 2'h1;
  localparam logic [1:0] TOK_SETUP = 2'h2;

  // Handshake codes to the serial engine.
  localparam logic [1:0] HS_ACK   = 2'h0;
  localparam logic [1:0] HS_NAK   = 2'h1;
  localparam logic [1:0] HS_STALL = 2'h2;

  // Endpoint numbering.
  localparam int EP_W = 4;
  localparam logic [EP_W-1:0] EP_CTRL = 4'h0;
  localparam int EXTRA_EP_NUM = 7;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RX_SETUP,
    ST_RX_OUT,
    ST_TX_IN,
    ST_WAIT_HS
  } ucem_state_e;

endpackage : ucem_pkg

/* File: core/ucem_ctrl_ep.sv */
// Endpoint-zero control transfer manager with register port and interrupt.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps

module ucem_ctrl_ep #(
  parameter int BUF_DEPTH = 8
) (
  input  wire logic                          CLK,
  input  wire logic                          RST,
  input  wire logic [ucem_pkg::ADDR_W-1:0]   ADDR,
  input  wire logic [ucem_pkg::DATA_W-1:0]   WDATA,
  input  wire logic                          WR,
  input  wire logic                          RD,
  output logic      [ucem_pkg::DATA_W-1:0]   RDATA,
  output logic                               IRQ,
  input  wire logic                          TOK_VALID,
  input  wire logic [1:0]                    TOK_PID,
  input  wire logic [ucem_pkg::EP_W-1:0]     TOK_EP,
  input  wire logic                          RX_VALID,
  input  wire logic [7:0]                    RX_DATA,
  input  wire logic                          RX_DATA1,
  input  wire logic                          RX_END,
  input  wire logic                          RX_ERR,
  output logic                               HS_VALID,
  output logic      [1:0]                    HS_CODE,
  output logic                               TX_VALID,
  output logic      [7:0]                    TX_DATA,
  output logic                               TX_DATA1,
  output logic                               TX_END,
  input  wire logic                          TX_READY,
  input  wire logic                          HOST_ACK,
  input  wire logic                          HOST_TIMEOUT
);

  localparam int IW = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CW = $clog2(BUF_DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(BUF_DEPTH);
  localparam logic [CW-1:0] ONE_C   = CW'(1);

  typedef struct packed {
    ucem_pkg::ucem_state_e             st;
    logic [CW-1:0]                     idx;
    logic                              acc;
    logic [1:0]                        code;
    logic                              setup_pend;
    logic [ucem_pkg::CFG_W-1:0]        out_cfg;
    logic [ucem_pkg::CFG_W-1:0]        in_cfg;
    logic [CW-1:0]                     out_cnt;
    logic [CW-1:0]                     in_cnt;
    logic [ucem_pkg::INT_W-1:0]        int_stat;
    logic [ucem_pkg::INT_W-1:0]        int_mask;
    logic [BUF_DEPTH-1:0][7:0]         setup_buf;
    logic [BUF_DEPTH-1:0][7:0]         out_buf;
    logic [BUF_DEPTH-1:0][7:0]         in_buf;
    logic                              hs_valid;
    logic [1:0]                        hs_code;
    logic [7:0]                        rdata;
  } ucem_regs_s;

  ucem_regs_s r_reg;
  ucem_regs_s r_next;

  logic [ucem_pkg::INT_W-1:0] ev;
  logic                       ep0_tok;
  logic [IW-1:0]              bus_idx;
  logic                       bus_idx_ok;

  assign ep0_tok    = TOK_VALID && (TOK_EP == ucem_pkg::EP_CTRL);
  assign bus_idx    = ADDR[IW-1:0];
  assign bus_idx_ok = ({4'h0, ADDR[3:0]} < BUF_DEPTH);

  always_comb begin
    logic [CW-1:0] wcnt;
    wcnt   = '0;
    r_next = r_reg;
    ev     = '0;
    r_next.hs_valid = 1'b0;
    r_next.rdata    = 8'h00;

    // Firmware writes; engine updates below take priority in the same cycle.
    if (WR) begin
      wcnt = (WDATA > 8'(BUF_DEPTH)) ? DEPTH_C : WDATA[CW-1:0];
      if (ADDR == ucem_pkg::INT_MASK_ADDR) begin
        r_next.int_mask = WDATA[ucem_pkg::INT_W-1:0];
      end else if (ADDR == ucem_pkg::OUT_CFG_ADDR) begin
        r_next.out_cfg = WDATA[ucem_pkg::CFG_W-1:0];
      end else if (ADDR == ucem_pkg::OUT_CNT_ADDR) begin
        r_next.out_cnt = wcnt;
      end else if (ADDR == ucem_pkg::IN_CFG_ADDR) begin
        r_next.in_cfg = WDATA[ucem_pkg::CFG_W-1:0];
      end else if (ADDR == ucem_pkg::IN_CNT_ADDR) begin
        r_next.in_cnt = wcnt;
      end else if (ADDR[7:4] == ucem_pkg::IN_BUF_PAGE && bus_idx_ok) begin
        r_next.in_buf[bus_idx] = WDATA;
      end
    end

    // Register reads; a read of the interrupt status clears it.
    if (RD) begin
      if (ADDR == ucem_pkg::USB_STAT_ADDR) begin
        r_next.rdata = {7'h00, r_reg.setup_pend};
      end else if (ADDR == ucem_pkg::INT_STAT_ADDR) begin
        r_next.rdata    = {5'h00, r_reg.int_stat};
        r_next.int_stat = '0;
        if (r_reg.int_stat[ucem_pkg::INT_SETUP]) begin
          r_next.setup_pend = 1'b0;
        end
      end else if (ADDR == ucem_pkg::INT_MASK_ADDR) begin
        r_next.rdata = {5'h00, r_reg.int_mask};
      end else if (ADDR == ucem_pkg::OUT_CFG_ADDR) begin
        r_next.rdata = {3'h0, r_reg.out_cfg};
      end else if (ADDR == ucem_pkg::OUT_CNT_ADDR) begin
        r_next.rdata = 8'(r_reg.out_cnt);
      end else if (ADDR == ucem_pkg::IN_CFG_ADDR) begin
        r_next.rdata = {3'h0, r_reg.in_cfg};
      end else if (ADDR == ucem_pkg::IN_CNT_ADDR) begin
        r_next.rdata = 8'(r_reg.in_cnt);
      end else if (bus_idx_ok) begin
        if (ADDR[7:4] == ucem_pkg::SETUP_BUF_PAGE) begin
          r_next.rdata = r_reg.setup_buf[bus_idx];
        end else if (ADDR[7:4] == ucem_pkg::OUT_BUF_PAGE) begin
          r_next.rdata = r_reg.out_buf[bus_idx];
        end else if (ADDR[7:4] == ucem_pkg::IN_BUF_PAGE) begin
          r_next.rdata = r_reg.in_buf[bus_idx];
        end
      end
    end

    unique case (r_reg.st)
      ucem_pkg::ST_IDLE: begin
        if (ep0_tok) begin
          r_next.idx = '0;
          case (TOK_PID)
            ucem_pkg::TOK_SETUP: begin
              r_next.st = ucem_pkg::ST_RX_SETUP;
            end
            ucem_pkg::TOK_OUT: begin
              r_next.st = ucem_pkg::ST_RX_OUT;
              // Verdict is fixed at token time, sent after the data.
              r_next.acc = !r_reg.setup_pend
                         && !r_reg.out_cfg[ucem_pkg::CFG_STALL]
                         && !r_reg.out_cfg[ucem_pkg::CFG_HOLD]
                         && r_reg.out_cfg[ucem_pkg::CFG_EN];
              if (r_reg.setup_pend) begin
                r_next.code = ucem_pkg::HS_NAK;
              end else if (r_reg.out_cfg[ucem_pkg::CFG_STALL]) begin
                r_next.code = ucem_pkg::HS_STALL;
              end else if (r_reg.out_cfg[ucem_pkg::CFG_HOLD]
                           || !r_reg.out_cfg[ucem_pkg::CFG_EN]) begin
                r_next.code = ucem_pkg::HS_NAK;
              end else begin
                r_next.code = ucem_pkg::HS_ACK;
              end
            end
            ucem_pkg::TOK_IN: begin
              r_next.hs_valid = 1'b1;
              if (r_reg.setup_pend) begin
                r_next.hs_code = ucem_pkg::HS_NAK;
              end else if (r_reg.in_cfg[ucem_pkg::CFG_STALL]) begin
                r_next.hs_code = ucem_pkg::HS_STALL;
              end else if (r_reg.in_cfg[ucem_pkg::CFG_HOLD]
                           || !r_reg.in_cfg[ucem_pkg::CFG_EN]) begin
                r_next.hs_code = ucem_pkg::HS_NAK;
              end else begin
                r_next.hs_valid = 1'b0;
                r_next.st       = ucem_pkg::ST_TX_IN;
              end
            end
            default: begin
              r_next.st = ucem_pkg::ST_IDLE;
            end
          endcase
        end
      end
      ucem_pkg::ST_RX_SETUP: begin
        if (RX_VALID && r_reg.idx != DEPTH_C) begin
          r_next.setup_buf[r_reg.idx[IW-1:0]] = RX_DATA;
          r_next.idx = r_reg.idx + ONE_C;
        end
        if (RX_END) begin
          r_next.st = ucem_pkg::ST_IDLE;
          if (!RX_ERR) begin
            r_next.setup_pend = 1'b1;
            r_next.hs_valid   = 1'b1;
            r_next.hs_code    = ucem_pkg::HS_ACK;
            ev[ucem_pkg::INT_SETUP] = 1'b1;
          end
        end
      end
      ucem_pkg::ST_RX_OUT: begin
        // A repeated packet with the wrong sequence bit is not stored.
        if (RX_VALID && r_reg.acc && r_reg.idx != DEPTH_C
            && RX_DATA1 == r_reg.out_cfg[ucem_pkg::CFG_TOG]) begin
          r_next.out_buf[r_reg.idx[IW-1:0]] = RX_DATA;
          r_next.idx = r_reg.idx + ONE_C;
        end
        if (RX_END) begin
          r_next.st = ucem_pkg::ST_IDLE;
          if (!RX_ERR) begin
            r_next.hs_valid = 1'b1;
            r_next.hs_code  = r_reg.code;
            if (r_reg.acc
                && RX_DATA1 == r_reg.out_cfg[ucem_pkg::CFG_TOG]) begin
              r_next.out_cnt = r_reg.idx;
              r_next.out_cfg[ucem_pkg::CFG_TOG] =
                !r_reg.out_cfg[ucem_pkg::CFG_TOG];
              r_next.out_cfg[ucem_pkg::CFG_HOLD] = 1'b1;
              ev[ucem_pkg::INT_OUT] = r_reg.out_cfg[ucem_pkg::CFG_IE];
            end
          end
        end
      end
      ucem_pkg::ST_TX_IN: begin
        if (r_reg.idx == r_reg.in_cnt) begin
          r_next.st = ucem_pkg::ST_WAIT_HS;
        end else if (TX_READY) begin
          r_next.idx = r_reg.idx + ONE_C;
        end
      end
      ucem_pkg::ST_WAIT_HS: begin
        if (HOST_ACK) begin
          r_next.st = ucem_pkg::ST_IDLE;
          r_next.in_cfg[ucem_pkg::CFG_TOG] =
            !r_reg.in_cfg[ucem_pkg::CFG_TOG];
          r_next.in_cfg[ucem_pkg::CFG_HOLD] = 1'b1;
          ev[ucem_pkg::INT_IN] = r_reg.in_cfg[ucem_pkg::CFG_IE];
        end else if (HOST_TIMEOUT) begin
          r_next.st = ucem_pkg::ST_IDLE;
        end
      end
    endcase

    // A new event wins over a read-clear in the same cycle.
    r_next.int_stat = r_next.int_stat | ev;
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      r_reg <= '{st: ucem_pkg::ST_IDLE,
                 out_cfg: ucem_pkg::CFG_RESET,
                 in_cfg: ucem_pkg::CFG_RESET,
                 int_stat: ucem_pkg::INT_RESET,
                 int_mask: ucem_pkg::INT_RESET,
                 default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  // Tokens for endpoints 1 to EXTRA_EP_NUM belong to the other managers.
  assign RDATA    = r_reg.rdata;
  assign IRQ      = |(r_reg.int_stat & r_reg.int_mask);
  assign HS_VALID = r_reg.hs_valid;
  assign HS_CODE  = r_reg.hs_code;
  assign TX_VALID = (r_reg.st == ucem_pkg::ST_TX_IN)
                    && (r_reg.idx != r_reg.in_cnt);
  assign TX_END   = (r_reg.st == ucem_pkg::ST_TX_IN)
                    && (r_reg.idx == r_reg.in_cnt);
  assign TX_DATA  = (r_reg.idx < DEPTH_C) ?
                    r_reg.in_buf[r_reg.idx[IW-1:0]] : 8'h00;
  assign TX_DATA1 = r_reg.in_cfg[ucem_pkg::CFG_TOG];

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  setup_ack_a: assert property (
    r_reg.st == ucem_pkg::ST_RX_SETUP && RX_END && !RX_ERR
    |=> HS_VALID && HS_CODE == ucem_pkg::HS_ACK && r_reg.setup_pend
        && r_reg.int_stat[ucem_pkg::INT_SETUP])
    else $error("setup packet not acknowledged and flagged");

  pending_nak_a: assert property (
    r_reg.st == ucem_pkg::ST_IDLE && ep0_tok && TOK_PID == ucem_pkg::TOK_IN
    && r_reg.setup_pend
    |=> HS_VALID && HS_CODE == ucem_pkg::HS_NAK)
    else $error("IN token not refused while setup pending");

  setup_clear_a: assert property (
    RD && ADDR == ucem_pkg::INT_STAT_ADDR
    && r_reg.int_stat[ucem_pkg::INT_SETUP] && !ev[ucem_pkg::INT_SETUP]
    |=> !r_reg.setup_pend)
    else $error("setup pending survived interrupt clear");

  out_accept_a: assert property (
    r_reg.st == ucem_pkg::ST_RX_OUT && RX_END && !RX_ERR && r_reg.acc
    && RX_DATA1 == r_reg.out_cfg[ucem_pkg::CFG_TOG]
    |=> r_reg.out_cfg[ucem_pkg::CFG_HOLD]
        && r_reg.out_cfg[ucem_pkg::CFG_TOG]
           != $past(r_reg.out_cfg[ucem_pkg::CFG_TOG])
        && HS_VALID && HS_CODE == ucem_pkg::HS_ACK)
    else $error("OUT data accept did not update endpoint");

  stall_reply_a: assert property (
    r_reg.st == ucem_pkg::ST_IDLE && ep0_tok && TOK_PID == ucem_pkg::TOK_IN
    && !r_reg.setup_pend && r_reg.in_cfg[ucem_pkg::CFG_STALL]
    |=> HS_VALID && HS_CODE == ucem_pkg::HS_STALL)
    else $error("stalled endpoint did not answer STALL");

  error_silent_a: assert property (
    (r_reg.st == ucem_pkg::ST_RX_OUT || r_reg.st == ucem_pkg::ST_RX_SETUP)
    && RX_END && RX_ERR
    |=> !HS_VALID ##1 (!HS_VALID || $past(ep0_tok)))
    else $error("handshake sent for corrupt packet");

  in_ack_a: assert property (
    r_reg.st == ucem_pkg::ST_WAIT_HS && HOST_ACK
    |=> r_reg.in_cfg[ucem_pkg::CFG_HOLD] && TX_DATA1 != $past(TX_DATA1)
        && r_reg.st == ucem_pkg::ST_IDLE)
    else $error("IN acknowledge did not update endpoint");

  in_retry_a: assert property (
    r_reg.st == ucem_pkg::ST_WAIT_HS && !HOST_ACK && HOST_TIMEOUT && !WR
    |=> $stable(r_reg.in_cfg) && r_reg.st == ucem_pkg::ST_IDLE)
    else $error("flags changed after missing handshake");

  irq_level_a: assert property (
    |(r_reg.int_stat & r_reg.int_mask) && !RD && !WR |=> IRQ)
    else $error("interrupt dropped without a clear");

endmodule : ucem_ctrl_ep

/* File: testbench/ucem_host_model.sv */
// Host and serial engine model facing the endpoint-zero manager.
`timescale 1ns/1ps
module ucem_host_model (
  input  wire logic       CLK,
  output logic            TOK_VALID,
  output logic [1:0]      TOK_PID,
  output logic [3:0]      TOK_EP,
  output logic            RX_VALID,
  output logic [7:0]      RX_DATA,
  output logic            RX_DATA1,
  output logic            RX_END,
  output logic            RX_ERR,
  input  wire logic       HS_VALID,
  input  wire logic [1:0] HS_CODE,
  input  wire logic       TX_VALID,
  input  wire logic [7:0] TX_DATA,
  input  wire logic       TX_DATA1,
  input  wire logic       TX_END,
  output logic            TX_READY,
  output logic            HOST_ACK,
  output logic            HOST_TIMEOUT
);
  logic [3:0] hs_cnt;
  logic [3:0] ep_sel;
  logic [1:0] hs_last;

  initial begin
    {TOK_VALID, TOK_PID, TOK_EP, RX_VALID, RX_DATA1, RX_END, RX_ERR} = '0;
    {HOST_ACK, HOST_TIMEOUT, hs_cnt, hs_last} = '0;
    RX_DATA = 8'h5a;
    TX_READY = 1'b1;
    ep_sel = ucem_pkg::EP_CTRL;
  end

  // Every handshake is counted so that a missing or doubled one shows.
  always @(posedge CLK) begin
    if (HS_VALID === 1'b1) begin
      hs_cnt <= hs_cnt + 4'h1;
      hs_last <= HS_CODE;
    end
  end

  task automatic out_pkt(input logic [1:0] pid, input logic d1,
                         input logic [3:0] n, input logic [63:0] dat,
                         input logic err, output logic [3:0] hs,
                         output logic [1:0] code);
    logic [3:0] h0;
    h0 = hs_cnt;
    @(posedge CLK);
    TOK_VALID <= 1'b1;
    TOK_PID <= pid;
    TOK_EP <= ep_sel;
    RX_DATA1 <= d1;
    for (int i = 0; i < n; i++) begin
      @(posedge CLK);
      TOK_VALID <= 1'b0;
      RX_VALID <= 1'b1;
      RX_DATA <= dat[8*i+:8];
    end
    @(posedge CLK);
    TOK_VALID <= 1'b0;
    RX_VALID <= 1'b0;
    RX_END <= 1'b1;
    RX_ERR <= err;
    RX_DATA <= ~RX_DATA;
    @(posedge CLK);
    RX_END <= 1'b0;
    RX_ERR <= 1'b0;
    RX_DATA1 <= ~d1;
    repeat (3) @(posedge CLK);
    hs = hs_cnt - h0;
    code = hs_last;
  endtask : out_pkt

  task automatic in_pkt(input logic slow, ack, output logic ended,
                        output logic [3:0] cnt, output logic [63:0] got,
                        output logic d1, output logic [3:0] hs,
                        output logic [1:0] code);
    logic [3:0] h0;
    h0 = hs_cnt;
    {ended, cnt, got, d1} = '0;
    @(posedge CLK);
    TOK_VALID <= 1'b1;
    TOK_PID <= ucem_pkg::TOK_IN;
    TOK_EP <= ep_sel;
    @(posedge CLK);
    TOK_VALID <= 1'b0;
    for (int k = 0; k < 24 && !ended; k++) begin
      @(posedge CLK);
      if (TX_VALID === 1'b1 && TX_READY === 1'b1) begin
        got[8*cnt+:8] = TX_DATA;
        cnt = cnt + 4'h1;
      end
      if (TX_END === 1'b1) begin
        ended = 1'b1;
        d1 = TX_DATA1;
      end
      if (slow) TX_READY <= ~TX_READY;
    end
    TX_READY <= 1'b1;
    if (ended) begin
      repeat (2) @(posedge CLK);
      HOST_ACK <= ack;
      HOST_TIMEOUT <= ~ack;
      @(posedge CLK);
      HOST_ACK <= 1'b0;
      HOST_TIMEOUT <= 1'b0;
    end
    repeat (2) @(posedge CLK);
    hs = hs_cnt - h0;
    code = hs_last;
  endtask : in_pkt
endmodule : ucem_host_model

/* File: testbench/ucem_ctrl_ep_test.sv */
// Self-checking bench for the endpoint-zero control manager.
`timescale 1ns/1ps
module ucem_ctrl_ep_test;
  logic        CLK, RST, WR, RD, IRQ, TOK_VALID, RX_VALID, RX_DATA1, RX_END;
  logic        RX_ERR, HS_VALID, TX_VALID, TX_DATA1, TX_END, TX_READY;
  logic        HOST_ACK, HOST_TIMEOUT, tog;
  logic [7:0]  ADDR, WDATA, RDATA, RX_DATA, TX_DATA;
  logic [1:0]  TOK_PID, HS_CODE;
  logic [3:0]  TOK_EP, n;
  logic [15:0] lfsr;
  logic [63:0] dat;
  int          num_errors, tests_run;
  int          cycles = 0;

  ucem_ctrl_ep i_ucem_ctrl_ep (.CLK(CLK), .RST(RST), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ),
    .TOK_VALID(TOK_VALID), .TOK_PID(TOK_PID), .TOK_EP(TOK_EP),
    .RX_VALID(RX_VALID), .RX_DATA(RX_DATA), .RX_DATA1(RX_DATA1),
    .RX_END(RX_END), .RX_ERR(RX_ERR), .HS_VALID(HS_VALID),
    .HS_CODE(HS_CODE), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA),
    .TX_DATA1(TX_DATA1), .TX_END(TX_END), .TX_READY(TX_READY),
    .HOST_ACK(HOST_ACK), .HOST_TIMEOUT(HOST_TIMEOUT));
  ucem_host_model i_ucem_host_model (.CLK(CLK), .TOK_VALID(TOK_VALID),
    .TOK_PID(TOK_PID), .TOK_EP(TOK_EP), .RX_VALID(RX_VALID),
    .RX_DATA(RX_DATA), .RX_DATA1(RX_DATA1), .RX_END(RX_END),
    .RX_ERR(RX_ERR), .HS_VALID(HS_VALID), .HS_CODE(HS_CODE),
    .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_DATA1(TX_DATA1),
    .TX_END(TX_END), .TX_READY(TX_READY), .HOST_ACK(HOST_ACK),
    .HOST_TIMEOUT(HOST_TIMEOUT));

  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  function automatic logic [15:0] nxt(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt

  function automatic logic [7:0] cfgv(logic t, logic h, logic s);
    logic [7:0] v;
    v = 8'h00;
    v[ucem_pkg::CFG_EN] = 1'b1;
    v[ucem_pkg::CFG_TOG] = t;
    v[ucem_pkg::CFG_HOLD] = h;
    v[ucem_pkg::CFG_STALL] = s;
    v[ucem_pkg::CFG_IE] = 1'b1;
    return v;
  endfunction : cfgv

  task automatic test_done;
    $display("Checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [63:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask : chk

  task automatic fill;
    for (int i = 0; i < 8; i++) begin
      lfsr = nxt(lfsr);
      dat[8*i+:8] = lfsr[7:0];
    end
  endtask : fill

  task automatic wr(input logic [7:0] a, v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask : wr

  task automatic rc(input logic [7:0] a, exp);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk(RDATA, exp);
  endtask : rc

  task automatic irq(input logic e);
    @(posedge CLK);
    #1 chk(IRQ, e);
  endtask : irq

  task automatic xout(input logic [1:0] pid, input logic d1, e,
                      input logic [3:0] ehs, input logic [1:0] ec);
    logic [3:0] hs;
    logic [1:0] c;
    i_ucem_host_model.out_pkt(pid, d1, n, dat, e, hs, c);
    chk(hs, ehs);
    if (ehs != 4'h0) chk(c, ec);
  endtask : xout

  task automatic xin(input logic slow, ack, ee, ed1,
                     input logic [3:0] ehs, input logic [1:0] ec);
    logic       ended, d1;
    logic [3:0] hs, cnt;
    logic [1:0] c;
    logic [63:0] got, m;
    i_ucem_host_model.in_pkt(slow, ack, ended, cnt, got, d1, hs, c);
    m = (64'h0000_0000_0000_0001 << (8 * n)) - 64'h0000_0000_0000_0001;
    chk(ended, ee);
    chk(hs, ehs);
    if (ehs != 4'h0) chk(c, ec);
    if (ee) begin
      chk(cnt, n);
      chk(got, dat & m);
      chk(d1, ed1);
    end
  endtask : xin

  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      test_done;
    end
  end

  initial begin
    {RST, ADDR, WDATA, WR, RD} = {1'b1, 18'h0_0000};
    {lfsr, num_errors, tests_run} = {16'h0001, 64'h0000_0000_0000_0000};
    repeat (20) @(posedge CLK);
    RST <= 1'b0;
    rc(ucem_pkg::OUT_CFG_ADDR, 8'h00);
    rc(ucem_pkg::INT_MASK_ADDR, 8'h00);
    rc(8'hFF, 8'h00);
    xin(1'b0, 1'b1, 1'b0, 1'b0, 4'h1, ucem_pkg::HS_NAK);
    wr(ucem_pkg::OUT_CFG_ADDR, cfgv(1'b0, 1'b0, 1'b0));
    wr(ucem_pkg::IN_CFG_ADDR, cfgv(1'b0, 1'b0, 1'b0));
    rc(ucem_pkg::IN_CFG_ADDR, cfgv(1'b0, 1'b0, 1'b0));
    fill;
    n = 4'h8;
    xout(ucem_pkg::TOK_SETUP, 1'b0, 1'b0, 4'h1, ucem_pkg::HS_ACK);
    rc(ucem_pkg::USB_STAT_ADDR, 8'h01);
    irq(1'b0);
    for (int i = 0; i < 8; i++) begin
      rc({ucem_pkg::SETUP_BUF_PAGE, 4'(i)}, dat[8*i+:8]);
    end
    wr({ucem_pkg::SETUP_BUF_PAGE, 4'h0}, ~dat[7:0]);
    rc({ucem_pkg::SETUP_BUF_PAGE, 4'h0}, dat[7:0]);
    wr(ucem_pkg::OUT_CFG_ADDR, cfgv(1'b1, 1'b1, 1'b1));
    n = 4'h1;
    xout(ucem_pkg::TOK_OUT, 1'b1, 1'b0, 4'h1, ucem_pkg::HS_NAK);
    xin(1'b0, 1'b1, 1'b0, 1'b0, 4'h1, ucem_pkg::HS_NAK);
    wr(ucem_pkg::INT_MASK_ADDR, 8'h07);
    irq(1'b1);
    rc(ucem_pkg::INT_STAT_ADDR, 8'h01);
    rc(ucem_pkg::USB_STAT_ADDR, 8'h00);
    irq(1'b0);
    xout(ucem_pkg::TOK_OUT, 1'b1, 1'b0, 4'h1, ucem_pkg::HS_STALL);
    wr(ucem_pkg::OUT_CFG_ADDR, cfgv(1'b1, 1'b0, 1'b0));
    xout(ucem_pkg::TOK_OUT, 1'b0, 1'b0, 4'h1, ucem_pkg::HS_ACK);
    rc(ucem_pkg::OUT_CFG_ADDR, cfgv(1'b1, 1'b0, 1'b0));
    tog = 1'b1;
    repeat (2) begin
      fill;
      n = 4'(lfsr[2:0]) + 4'h1;
      xout(ucem_pkg::TOK_OUT, tog, 1'b0, 4'h1, ucem_pkg::HS_ACK);
      rc(ucem_pkg::OUT_CNT_ADDR, 8'(n));
      for (int i = 0; i < n; i++) begin
        rc({ucem_pkg::OUT_BUF_PAGE, 4'(i)}, dat[8*i+:8]);
      end
      rc(ucem_pkg::OUT_CFG_ADDR, cfgv(~tog, 1'b1, 1'b0));
      irq(1'b1);
      xout(ucem_pkg::TOK_OUT, ~tog, 1'b0, 4'h1, ucem_pkg::HS_NAK);
      rc(ucem_pkg::INT_STAT_ADDR, 8'h02);
      wr(ucem_pkg::OUT_CFG_ADDR, cfgv(~tog, 1'b0, 1'b0));
      tog = ~tog;
    end
    n = 4'h2;
    xout(ucem_pkg::TOK_OUT, tog, 1'b1, 4'h0, ucem_pkg::HS_ACK);
    rc(ucem_pkg::OUT_CFG_ADDR, cfgv(tog, 1'b0, 1'b0));
    wr(ucem_pkg::IN_CNT_ADDR, 8'hFF);
    rc(ucem_pkg::IN_CNT_ADDR, 8'h08);
    wr(ucem_pkg::IN_CNT_ADDR, 8'h00);
    wr(ucem_pkg::IN_CFG_ADDR, cfgv(1'b1, 1'b0, 1'b0));
    n = 4'h0;
    xin(1'b0, 1'b0, 1'b1, 1'b1, 4'h0, ucem_pkg::HS_ACK);
    rc(ucem_pkg::IN_CFG_ADDR, cfgv(1'b1, 1'b0, 1'b0));
    xin(1'b0, 1'b1, 1'b1, 1'b1, 4'h0, ucem_pkg::HS_ACK);
    rc(ucem_pkg::IN_CFG_ADDR, cfgv(1'b0, 1'b1, 1'b0));
    rc(ucem_pkg::INT_STAT_ADDR, 8'h04);
    xin(1'b0, 1'b1, 1'b0, 1'b0, 4'h1, ucem_pkg::HS_NAK);
    fill;
    n = 4'h8;
    xout(ucem_pkg::TOK_SETUP, 1'b0, 1'b0, 4'h1, ucem_pkg::HS_ACK);
    rc(ucem_pkg::INT_STAT_ADDR, 8'h01);
    fill;
    n = 4'(lfsr[2:0]) + 4'h1;
    for (int i = 0; i < n; i++) begin
      wr({ucem_pkg::IN_BUF_PAGE, 4'(i)}, dat[8*i+:8]);
    end
    wr(ucem_pkg::IN_CNT_ADDR, 8'(n));
    wr(ucem_pkg::IN_CFG_ADDR, cfgv(1'b1, 1'b0, 1'b0));
    xin(1'b1, 1'b1, 1'b1, 1'b1, 4'h0, ucem_pkg::HS_ACK);
    wr(ucem_pkg::OUT_CFG_ADDR, cfgv(1'b1, 1'b0, 1'b0));
    n = 4'h0;
    xout(ucem_pkg::TOK_OUT, 1'b1, 1'b0, 4'h1, ucem_pkg::HS_ACK);
    rc(ucem_pkg::OUT_CNT_ADDR, 8'h00);
    rc(ucem_pkg::OUT_CFG_ADDR, cfgv(1'b0, 1'b1, 1'b0));
    wr(ucem_pkg::IN_CFG_ADDR, cfgv(1'b0, 1'b0, 1'b1));
    i_ucem_host_model.ep_sel = 4'h1;
    xin(1'b0, 1'b1, 1'b0, 1'b0, 4'h0, ucem_pkg::HS_STALL);
    i_ucem_host_model.ep_sel = ucem_pkg::EP_CTRL;
    xin(1'b0, 1'b1, 1'b0, 1'b0, 4'h1, ucem_pkg::HS_STALL);
    test_done;
  end
endmodule : ucem_ctrl_ep_test
